//--- logic/fpc_top.sv
// Real operand classifier: decode, class, traps, NaN results, range checks.
`timescale 1ns/1ps
// Function
// - Single/double zero exponent: denormal, integer zero
// - Extended zero exponent with integer one: normal
// - Normal: implied or explicit integer bit one
// - Underflow when exponent at or below minimum
// - Underflow shifts mantissa right, zero when empty
// - Extended nonzero exponent, integer zero: unnormal
// - Denormal or unnormal operand raises unimplemented trap
// - Overflow when exponent at or above maximum
// - Extended infinity/NaN ignores the integer bit
// - Any NaN operand yields a NaN result, except a trapped signaling NaN
// - Leading fraction bit one quiet, zero signaling
// - Never output a signaling NaN
// - Untrapped signaling NaN is quieted and passed
// - Generated NaN has all mantissa bits one
// - Single: sign 31, exponent 30:23, fraction 22:0
// - Single normal: bias 127, exponent 1 to 254
// - Single denormal: two to minus 126 times 0.f
// - Zero, infinity, NaN decoded from exponent and fraction
// - Double: sign 63, exponent 62:52, fraction 51:0
// - Sign zero positive, sign one negative
// - Double: 11-bit exponent, bias 1023, 52-bit fraction
// - Extended: 96 bits, bias 16383, 16 reserved zeros
module fpc_top
   import fpc_pkg::*;
#(
   parameter int MANT_W = FPC_MANT_W
)
(
   // Clock, reset and enable.
   input  wire logic               mclk,
   input  wire logic               rst_n,
   input  wire logic               ce,
   // Operands.
   input  wire logic               op_valid,
   input  wire fpc_fmt_type        op_fmt,
   input  wire logic [95:0]        op_a,
   input  wire logic [95:0]        op_b,
   input  wire logic               op_dyadic,
   input  wire logic               gen_nan,
   input  wire logic               nan_trap_en,
   // Result to check.
   input  wire logic signed [16:0] res_exp,
   input  wire logic [63:0]        res_mant,
   // Valid flag, decoded operand A and class of operand B.
   output logic                    out_valid,
   output logic                    a_sign,
   output logic [14:0]             a_exp,
   output logic [63:0]             a_mant,
   output logic [6:0]              a_class,
   output logic [6:0]              b_class,
   // Traps and NaN result.
   output logic                    trap_unimpl,
   output logic                    signaling_not_a_number,
   output logic                    nan_valid,
   output logic [95:0]             nan_word,
   // Range checks.
   output logic                    underflow,
   output logic                    overflow,
   output logic signed [16:0]      den_exp,
   output logic [63:0]             den_mant
);

   generate
      if (MANT_W != FPC_MANT_W) begin : g_bad_width
         $error("fpc_top serves only a 64-bit mantissa");
      end
   endgenerate

   fpc_cls_if cls_a ();
   fpc_cls_if cls_b ();

   logic [95:0]        opnd [2];
   logic [6:0]         cls_v [2];

   assign opnd[0]  = op_a;
   assign opnd[1]  = op_b;
   assign cls_v[0] = cls_a.cls;
   assign cls_v[1] = cls_b.cls;

   fpc_unpack u_unpack_a (
      .fmt    (op_fmt),
      .data   (op_a),
      .cls_if (cls_a)
   );

   fpc_unpack u_unpack_b (
      .fmt    (op_fmt),
      .data   (op_b),
      .cls_if (cls_b)
   );

   logic               next_underflow;
   logic               next_overflow;
   logic signed [16:0] next_den_exp;
   logic [63:0]        next_den_mant;

   fpc_denorm u_denorm (
      .fmt       (op_fmt),
      .res_exp   (res_exp),
      .res_mant  (res_mant),
      .underflow (next_underflow),
      .overflow  (next_overflow),
      .den_exp   (next_den_exp),
      .den_mant  (next_den_mant)
   );

   // Sets the leading fraction bit and clears reserved bits of a NaN.
   function automatic logic [95:0] fpc_quiet(input fpc_fmt_type fmt,
                                             input logic [95:0] d);
      fpc_quiet = d;
      unique case (fmt)
         FPC_FMT_SINGLE: begin
            fpc_quiet = {64'h0, d[31:0]};
            fpc_quiet[FPC_SGL_FRAC_HI] = 1'b1;
         end
         FPC_FMT_DOUBLE: begin
            fpc_quiet = {32'h0, d[63:0]};
            fpc_quiet[FPC_DBL_FRAC_HI] = 1'b1;
         end
         default: begin
            fpc_quiet[FPC_EXT_RSV_HI:FPC_EXT_RSV_LO] = 16'h0;
            fpc_quiet[FPC_EXT_FRAC_HI] = 1'b1;
         end
      endcase
   endfunction : fpc_quiet

   function automatic logic [95:0] fpc_gen(input fpc_fmt_type fmt);
      unique case (fmt)
         FPC_FMT_SINGLE: fpc_gen = FPC_SGL_GEN_NAN;
         FPC_FMT_DOUBLE: fpc_gen = FPC_DBL_GEN_NAN;
         default:        fpc_gen = FPC_EXT_GEN_NAN;
      endcase
   endfunction : fpc_gen

   logic [1:0]  used;
   logic [1:0]  is_nan;
   logic [1:0]  is_sig;
   logic [1:0]  is_unimpl;
   logic        next_trap;
   logic        next_sig;
   logic        next_nan_valid;
   logic [95:0] next_nan_word;

   // Per-operand flags; operand B counts only for two-operand work.
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_flags
         assign used[gi]      = (gi == 0) ? 1'b1 : op_dyadic;
         assign is_sig[gi]    = used[gi] & cls_v[gi][FPC_CLS_SIGNAL];
         assign is_nan[gi]    = used[gi] &
                                (cls_v[gi][FPC_CLS_QNAN] | is_sig[gi]);
         assign is_unimpl[gi] = used[gi] &
                                (cls_v[gi][FPC_CLS_DENORM] |
                                 cls_v[gi][FPC_CLS_UNNORM]);
      end
   endgenerate

   always_comb begin
      next_trap      = |is_unimpl;
      next_sig       = (|is_sig) & nan_trap_en;
      next_nan_valid = 1'b0;
      next_nan_word  = FPC_RST_WORD;
      if (|is_nan) begin
         // A trapped signaling NaN produces no result at all.
         next_nan_valid = ~next_sig;
         // Operand A wins when both are NaNs.
         next_nan_word  = fpc_quiet(op_fmt,
                                    is_nan[0] ? opnd[0] : opnd[1]);
      end else if (gen_nan) begin
         next_nan_valid = 1'b1;
         next_nan_word  = fpc_gen(op_fmt);
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         out_valid <= 1'b0;
      end else if (ce) begin
         out_valid <= op_valid;
      end
   end

   // Decoded fields and class vectors.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         a_sign  <= 1'b0;
         a_exp   <= 15'h0;
         a_mant  <= 64'h0;
         a_class <= FPC_RST_CLS;
         b_class <= FPC_RST_CLS;
      end else if (ce && op_valid) begin
         a_sign  <= cls_a.sign;
         a_exp   <= cls_a.exp;
         a_mant  <= cls_a.mant;
         a_class <= cls_a.cls;
         b_class <= op_dyadic ? cls_b.cls : FPC_RST_CLS;
      end
   end

   // Trap requests and NaN result.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         trap_unimpl            <= 1'b0;
         signaling_not_a_number <= 1'b0;
         nan_valid              <= 1'b0;
         nan_word               <= FPC_RST_WORD;
      end else if (ce) begin
         trap_unimpl            <= op_valid & next_trap;
         signaling_not_a_number <= op_valid & next_sig;
         nan_valid              <= op_valid & next_nan_valid;
         nan_word               <= next_nan_word;
      end
   end

   // Result range checks.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         underflow <= 1'b0;
         overflow  <= 1'b0;
         den_exp   <= 17'sh0;
         den_mant  <= 64'h0;
      end else if (ce) begin
         underflow <= op_valid & next_underflow;
         overflow  <= op_valid & next_overflow;
         den_exp   <= next_den_exp;
         den_mant  <= next_den_mant;
      end
   end

   // Checks on the registered outputs.
   class_onehot_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      out_valid |-> $onehot(a_class))
      else $error("operand class is not one-hot");

   single_denorm_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      ce && op_valid && op_fmt == FPC_FMT_SINGLE && op_a[30:23] == 8'h00
      && op_a[22:0] != 23'h0
      |=> a_class[FPC_CLS_DENORM] && !a_mant[63] && trap_unimpl)
      else $error("single zero exponent not denormal with trap");

   ext_zero_norm_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      ce && op_valid && op_fmt == FPC_FMT_EXT && op_a[94:80] == 15'h0
      && op_a[63] && !op_dyadic
      |=> a_class[FPC_CLS_NORM] && !trap_unimpl)
      else $error("extended zero exponent with integer one not normal");

   ext_unnorm_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      ce && op_valid && op_fmt == FPC_FMT_EXT && op_a[94:80] != 15'h0
      && op_a[94:80] != 15'h7fff && !op_a[63]
      |=> a_class[FPC_CLS_UNNORM] && trap_unimpl)
      else $error("unnormal extended operand missed");

   ext_inf_any_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      ce && op_valid && op_fmt == FPC_FMT_EXT && op_a[94:80] == 15'h7fff
      && op_a[62:0] == 63'h0 |=> a_class[FPC_CLS_INF])
      else $error("extended infinity misclassified");

   nan_result_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      ce && op_valid && !nan_trap_en
      && (cls_a.cls[FPC_CLS_QNAN] || cls_a.cls[FPC_CLS_SIGNAL])
      |=> nan_valid)
      else $error("NaN operand gave no NaN result");

   never_signal_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      ce && op_valid |=> !nan_valid
      || (nan_word[22] && $past(op_fmt) == FPC_FMT_SINGLE)
      || (nan_word[51] && $past(op_fmt) == FPC_FMT_DOUBLE)
      || (nan_word[62] && $past(op_fmt) == FPC_FMT_EXT))
      else $error("signaling NaN produced as a result");

   quiet_copy_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      ce && op_valid && !nan_trap_en && op_fmt == FPC_FMT_SINGLE
      && cls_a.cls[FPC_CLS_SIGNAL]
      |=> nan_word == {64'h0, $past(op_a[31:23]), 1'b1, $past(op_a[21:0])})
      else $error("signaling NaN not quieted from its source");

   gen_nan_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      ce && op_valid && gen_nan && op_fmt == FPC_FMT_EXT
      && !cls_a.cls[FPC_CLS_QNAN] && !cls_a.cls[FPC_CLS_SIGNAL]
      && !(op_dyadic && (cls_b.cls[FPC_CLS_QNAN] || cls_b.cls[FPC_CLS_SIGNAL]))
      |=> nan_valid && nan_word[63:0] == 64'hffffffffffffffff)
      else $error("generated NaN mantissa not all ones");

   under_flag_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      ce && op_valid && res_exp <= 17'sh0 |=> underflow && den_exp == 17'sh0)
      else $error("underflow not flagged at minimum exponent");

   under_zero_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      ce && op_valid && res_exp <= -17'sd64 |=> den_mant == 64'h0)
      else $error("fully shifted mantissa not zero");

   over_flag_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      ce && op_valid && op_fmt == FPC_FMT_SINGLE
      |=> overflow == ($past(res_exp) >= 17'sh000ff))
      else $error("single overflow threshold wrong");

endmodule : fpc_top

//--- logic/fpc_pkg.sv
// Shared formats, field positions, limits and class decoding.
package fpc_pkg;

   typedef enum logic [1:0] {
      FPC_FMT_SINGLE,
      FPC_FMT_DOUBLE,
      FPC_FMT_EXT
   } fpc_fmt_type;

   localparam int FPC_OP_W   = 96;
   localparam int FPC_MANT_W = 64;
   localparam int FPC_EXP_W  = 15;
   localparam int FPC_REXP_W = 17;
   localparam int FPC_CLS_W  = 7;

   // One-hot class positions.
   localparam int FPC_CLS_NORM   = 0;
   localparam int FPC_CLS_DENORM = 1;
   localparam int FPC_CLS_UNNORM = 2;
   localparam int FPC_CLS_ZERO   = 3;
   localparam int FPC_CLS_INF    = 4;
   localparam int FPC_CLS_QNAN   = 5;
   localparam int FPC_CLS_SIGNAL = 6;

   // Single precision layout and limits.
   localparam int FPC_SGL_SIGN    = 31;
   localparam int FPC_SGL_EXP_HI  = 30;
   localparam int FPC_SGL_EXP_LO  = 23;
   localparam int FPC_SGL_FRAC_HI = 22;
   localparam int FPC_SGL_BIAS    = 127;
   localparam int FPC_SGL_DEN_POW = 126;
   localparam logic [16:0] FPC_SGL_EMAX = 17'h000ff;

   // Double precision layout and limits.
   localparam int FPC_DBL_SIGN    = 63;
   localparam int FPC_DBL_EXP_HI  = 62;
   localparam int FPC_DBL_EXP_LO  = 52;
   localparam int FPC_DBL_FRAC_HI = 51;
   localparam int FPC_DBL_BIAS    = 1023;
   localparam logic [16:0] FPC_DBL_EMAX = 17'h007ff;

   // Extended precision layout and limits.
   localparam int FPC_EXT_SIGN    = 95;
   localparam int FPC_EXT_EXP_HI  = 94;
   localparam int FPC_EXT_EXP_LO  = 80;
   localparam int FPC_EXT_RSV_HI  = 79;
   localparam int FPC_EXT_RSV_LO  = 64;
   localparam int FPC_EXT_INT     = 63;
   localparam int FPC_EXT_FRAC_HI = 62;
   localparam int FPC_EXT_BIAS    = 16383;
   localparam logic [16:0] FPC_EXT_EMAX = 17'h07fff;

   localparam logic [16:0] FPC_EXP_MIN = 17'h00000;

   // Values after reset.
   localparam logic [6:0]  FPC_RST_CLS  = 7'h00;
   localparam logic [95:0] FPC_RST_WORD = 96'h0;

   // Generated NaN words: exponent at maximum, every mantissa bit one.
   localparam logic [95:0] FPC_SGL_GEN_NAN = 96'h7fffffff;
   localparam logic [95:0] FPC_DBL_GEN_NAN = 96'h7fffffffffffffff;
   localparam logic [95:0] FPC_EXT_GEN_NAN =
      96'h7fff0000ffffffffffffffff;

   function automatic logic [16:0] fpc_emax(input fpc_fmt_type fmt);
      unique case (fmt)
         FPC_FMT_SINGLE: fpc_emax = FPC_SGL_EMAX;
         FPC_FMT_DOUBLE: fpc_emax = FPC_DBL_EMAX;
         FPC_FMT_EXT:    fpc_emax = FPC_EXT_EMAX;
         default:        fpc_emax = FPC_EXT_EMAX;
      endcase
   endfunction : fpc_emax

endpackage : fpc_pkg

//--- logic/fpc_cls_if.sv
// Decoded fields and class of one operand, passed from unpacker to top.
`timescale 1ns/1ps
interface fpc_cls_if;
   logic        sign;
   logic [14:0] exp;
   logic [63:0] mant;
   logic [6:0]  cls;
   modport src (output sign, output exp, output mant, output cls);
   modport dst (input sign, input exp, input mant, input cls);
endinterface : fpc_cls_if

//--- logic/fpc_unpack.sv
// Splits one operand into sign, exponent and mantissa, and classifies it.
`timescale 1ns/1ps
module fpc_unpack
   import fpc_pkg::*;
(
   // Operand.
   input  wire fpc_fmt_type fmt,
   input  wire logic [95:0] data,
   // Decoded result.
   fpc_cls_if.src           cls_if
);

   logic        exp_zero;
   logic        exp_max;
   logic [62:0] frac;

   always_comb begin
      cls_if.sign = 1'b0;
      cls_if.exp  = 15'h0;
      cls_if.mant = 64'h0;
      exp_zero    = 1'b0;
      exp_max     = 1'b0;
      unique case (fmt)
         FPC_FMT_SINGLE: begin
            cls_if.sign = data[FPC_SGL_SIGN];
            cls_if.exp  = {7'h0, data[FPC_SGL_EXP_HI:FPC_SGL_EXP_LO]};
            exp_zero    = (cls_if.exp == 15'h0);
            exp_max     = ({2'h0, cls_if.exp} == FPC_SGL_EMAX);
            // Implied integer bit is one unless exponent is zero.
            cls_if.mant = {~exp_zero, data[FPC_SGL_FRAC_HI:0],
                           40'h0};
         end
         FPC_FMT_DOUBLE: begin
            cls_if.sign = data[FPC_DBL_SIGN];
            cls_if.exp  = {4'h0, data[FPC_DBL_EXP_HI:FPC_DBL_EXP_LO]};
            exp_zero    = (cls_if.exp == 15'h0);
            exp_max     = ({2'h0, cls_if.exp} == FPC_DBL_EMAX);
            cls_if.mant = {~exp_zero, data[FPC_DBL_FRAC_HI:0],
                           11'h0};
         end
         default: begin
            cls_if.sign = data[FPC_EXT_SIGN];
            cls_if.exp  = data[FPC_EXT_EXP_HI:FPC_EXT_EXP_LO];
            exp_zero    = (cls_if.exp == 15'h0);
            exp_max     = ({2'h0, cls_if.exp} == FPC_EXT_EMAX);
            cls_if.mant = data[FPC_EXT_INT:0];
         end
      endcase
   end

   assign frac = cls_if.mant[62:0];

   always_comb begin
      cls_if.cls = 7'h0;
      if (exp_max) begin
         // Integer bit is ignored for infinities and NaNs.
         if (frac == 63'h0)
            cls_if.cls[FPC_CLS_INF] = 1'b1;
         else if (frac[62])
            cls_if.cls[FPC_CLS_QNAN] = 1'b1;
         else
            cls_if.cls[FPC_CLS_SIGNAL] = 1'b1;
      end else if (exp_zero) begin
         if (fmt == FPC_FMT_EXT && cls_if.mant[63])
            cls_if.cls[FPC_CLS_NORM] = 1'b1;
         else if (frac == 63'h0)
            cls_if.cls[FPC_CLS_ZERO] = 1'b1;
         else
            cls_if.cls[FPC_CLS_DENORM] = 1'b1;
      end else if (!cls_if.mant[63]) begin
         cls_if.cls[FPC_CLS_UNNORM] = 1'b1;
      end else begin
         cls_if.cls[FPC_CLS_NORM] = 1'b1;
      end
   end

endmodule : fpc_unpack

//--- logic/fpc_denorm.sv
// Checks a result exponent against its format limits and denormalizes.
`timescale 1ns/1ps
module fpc_denorm
   import fpc_pkg::*;
(
   // Result in.
   input  wire fpc_fmt_type        fmt,
   input  wire logic signed [16:0] res_exp,
   input  wire logic [63:0]        res_mant,
   // Checked result out.
   output logic                    underflow,
   output logic                    overflow,
   output logic signed [16:0]      den_exp,
   output logic [63:0]             den_mant
);

   logic signed [16:0] emax;
   logic [16:0]        shift;

   always_comb begin
      emax      = fpc_emax(fmt);
      underflow = (res_exp <= $signed(FPC_EXP_MIN));
      overflow  = (res_exp >= emax);
      shift     = 17'(FPC_EXP_MIN - res_exp);
      den_exp   = res_exp;
      den_mant  = res_mant;
      if (underflow) begin
         // Right shift raises exponent to minimum; all bits gone gives zero.
         den_exp  = FPC_EXP_MIN;
         den_mant = (shift >= 17'd64) ? 64'h0 : (res_mant >> shift);
      end
   end

endmodule : fpc_denorm

//--- tb/fpc_pipe_model.sv
// Operand source standing in for the execution pipeline and operand fetch.
`timescale 1ns/1ps
module fpc_pipe_model
   import fpc_pkg::*;
(
   // Clock.
   input  wire logic          mclk,
   // Operation to the classifier.
   output logic               op_valid,
   output fpc_fmt_type        op_fmt,
   output logic [95:0]        op_a,
   output logic [95:0]        op_b,
   output logic               op_dyadic,
   output logic               gen_nan,
   output logic               nan_trap_en,
   output logic signed [16:0] res_exp,
   output logic [63:0]        res_mant
);
   initial begin
      op_valid    = 1'b0;
      op_fmt      = FPC_FMT_SINGLE;
      op_a        = 96'h0;
      op_b        = 96'h0;
      op_dyadic   = 1'b0;
      gen_nan     = 1'b0;
      nan_trap_en = 1'b0;
      res_exp     = 17'sh00001;
      res_mant    = 64'h0;
   end

   // Presents one operation at a falling edge for the next rising edge.
   task automatic issue(input fpc_fmt_type f, input logic [95:0] a,
                        input logic [95:0] b, input logic dy,
                        input logic gn, input logic te,
                        input logic signed [16:0] re,
                        input logic [63:0] rm);
      @(negedge mclk);
      op_valid    <= 1'b1;
      op_fmt      <= f;
      op_a        <= a;
      op_b        <= b;
      op_dyadic   <= dy;
      gen_nan     <= gn;
      nan_trap_en <= te;
      res_exp     <= re;
      res_mant    <= rm;
   endtask : issue

   // Idle operand lines carry the inverse, so a stale word is never reused.
   task automatic idle();
      @(negedge mclk);
      op_valid <= 1'b0;
      op_a     <= ~op_a;
      op_b     <= ~op_b;
      res_mant <= ~res_mant;
   endtask : idle
endmodule : fpc_pipe_model

//--- tb/fpc_top_tb.sv
// Self-checking bench for the real operand classifier.
`timescale 1ns/1ps
module fpc_top_tb
   import fpc_pkg::*;
;
   localparam logic [6:0] C_NRM = 7'h01;
   localparam logic [6:0] C_DEN = 7'h02;
   localparam logic [6:0] C_UNN = 7'h04;
   localparam logic [6:0] C_ZER = 7'h08;
   localparam logic [6:0] C_INF = 7'h10;
   localparam logic [6:0] C_QNN = 7'h20;
   localparam logic [6:0] C_SNN = 7'h40;
   localparam fpc_fmt_type SG = FPC_FMT_SINGLE;
   localparam fpc_fmt_type DB = FPC_FMT_DOUBLE;
   localparam fpc_fmt_type EX = FPC_FMT_EXT;

   logic               mclk = 1'b0;
   logic               rst_n = 1'b0;
   logic               ce = 1'b1;
   logic               op_valid, op_dyadic, gen_nan, nan_trap_en;
   fpc_fmt_type        op_fmt;
   logic [95:0]        op_a, op_b, nan_word;
   logic signed [16:0] res_exp, den_exp;
   logic [63:0]        res_mant, a_mant, den_mant;
   logic               out_valid, a_sign, trap_unimpl;
   logic               signaling_not_a_number, nan_valid;
   logic               underflow, overflow;
   logic [14:0]        a_exp;
   logic [6:0]         a_class, b_class;
   int                 fail_count = 0;
   int                 total_checks = 0;
   int                 cyc = 0;

   always #20 mclk = ~mclk;

   fpc_pipe_model u_fpc_pipe_model (.mclk(mclk), .op_valid(op_valid),
      .op_fmt(op_fmt), .op_a(op_a), .op_b(op_b), .op_dyadic(op_dyadic),
      .gen_nan(gen_nan), .nan_trap_en(nan_trap_en), .res_exp(res_exp),
      .res_mant(res_mant));

   fpc_top u_fpc_top (.mclk(mclk), .rst_n(rst_n), .ce(ce),
      .op_valid(op_valid), .op_fmt(op_fmt), .op_a(op_a), .op_b(op_b),
      .op_dyadic(op_dyadic), .gen_nan(gen_nan), .nan_trap_en(nan_trap_en),
      .res_exp(res_exp), .res_mant(res_mant), .out_valid(out_valid),
      .a_sign(a_sign), .a_exp(a_exp), .a_mant(a_mant), .a_class(a_class),
      .b_class(b_class), .trap_unimpl(trap_unimpl),
      .signaling_not_a_number(signaling_not_a_number),
      .nan_valid(nan_valid), .nan_word(nan_word), .underflow(underflow),
      .overflow(overflow), .den_exp(den_exp), .den_mant(den_mant));

   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : close_out

   always @(posedge mclk) begin
      cyc++;
      if (cyc > 5000) begin
         fail_count++;
         close_out();
      end
   end

   task automatic chk(input logic [95:0] got, input logic [95:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // One operation; outputs are looked at just after the answering edge.
   task automatic op(input fpc_fmt_type f, input logic [95:0] a,
                     input logic [95:0] b = 96'h0, input logic dy = 1'b0,
                     input logic gn = 1'b0, input logic te = 1'b0,
                     input logic signed [16:0] re = 17'sh00001,
                     input logic [63:0] rm = 64'h0);
      u_fpc_pipe_model.issue(f, a, b, dy, gn, te, re, rm);
      @(posedge mclk);
      #1;
   endtask : op

   task automatic t_single();
      op(SG, 96'h00000001);
      chk(out_valid, 1'b1);
      chk(a_class, C_DEN);
      chk(a_mant, 64'h0000010000000000);
      chk(trap_unimpl, 1'b1);
      op(SG, 96'hbf800000);
      chk(a_sign, 1'b1);
      chk(a_exp, 15'h007f);
      chk(a_mant, 64'h8000000000000000);
      chk(trap_unimpl, 1'b0);
      op(SG, 96'h7f7fffff);
      chk(a_class, C_NRM);
      chk(a_mant, 64'hffffff0000000000);
      op(SG, 96'h80000000);
      chk(a_class, C_ZER);
      op(SG, 96'hff800000);
      chk(a_class, C_INF);
      op(SG, 96'h7fc00001);
      chk(a_class, C_QNN);
      chk(nan_word, 96'h7fc00001);
      op(SG, 96'h7f800001);
      chk(a_class, C_SNN);
      chk(nan_valid, 1'b1);
      chk(nan_word, 96'h7fc00001);
      op(SG, 96'h7f800001, 96'h0, 1'b0, 1'b0, 1'b1);
      chk(signaling_not_a_number, 1'b1);
      chk(nan_valid, 1'b0);
   endtask : t_single

   task automatic t_double();
      op(DB, 96'h3ff0000000000000);
      chk(a_exp, 15'h03ff);
      chk(a_mant, 64'h8000000000000000);
      op(DB, 96'h0000000000000001);
      chk(a_class, C_DEN);
      chk(a_mant, 64'h0000000000000800);
      op(DB, 96'hfff0000000000000);
      chk(a_class, C_INF);
      chk(a_sign, 1'b1);
      op(DB, 96'h7ff0000000000001);
      chk(nan_word, 96'h7ff8000000000001);
   endtask : t_double

   task automatic t_ext();
      op(EX, 96'h000000008000000000000000);
      chk(a_class, C_NRM);
      chk(trap_unimpl, 1'b0);
      op(EX, 96'h3fff00004000000000000000);
      chk(a_class, C_UNN);
      chk(trap_unimpl, 1'b1);
      op(EX, 96'h000000000000000000000001);
      chk(a_class, C_DEN);
      op(EX, 96'h7fff00000000000000000000);
      chk(a_class, C_INF);
      op(EX, 96'hffff00008000000000000000);
      chk(a_class, C_INF);
      op(EX, 96'h7fff00004000000000000001);
      chk(a_class, C_QNN);
      op(EX, 96'h7fff00008000000000000001);
      chk(a_class, C_SNN);
      chk(nan_word, 96'h7fff0000c000000000000001);
      op(EX, 96'hbffe0000c000000000000000);
      chk(a_exp, 15'h3ffe);
      chk(a_mant, 64'hc000000000000000);
   endtask : t_ext

   task automatic t_gen();
      op(SG, 96'h3f800000, 96'h3f800000, 1'b1, 1'b1);
      chk(nan_word, 96'h7fffffff);
      op(DB, 96'h3ff0000000000000, 96'h0, 1'b0, 1'b1);
      chk(nan_word, 96'h7fffffffffffffff);
      op(EX, 96'h3fff00008000000000000000, 96'h0, 1'b0, 1'b1);
      chk(nan_valid, 1'b1);
      chk(nan_word, 96'h7fff0000ffffffffffffffff);
   endtask : t_gen

   task automatic t_dyadic();
      op(SG, 96'h3f800000, 96'h7f800001, 1'b1);
      chk(b_class, C_SNN);
      chk(nan_word, 96'h7fc00001);
      op(SG, 96'h3f800000, 96'h7f800001, 1'b0);
      chk(b_class, 7'h00);
      chk(nan_valid, 1'b0);
      op(SG, 96'h3f800000, 96'h00000001, 1'b1);
      chk(trap_unimpl, 1'b1);
      op(SG, 96'h7fc00002, 96'h7fc00001, 1'b1);
      chk(nan_word, 96'h7fc00002);
   endtask : t_dyadic

   // Range check of one result with the expectation worked out here.
   task automatic rng(input fpc_fmt_type f, input int re, input logic uf,
                      input logic ofl);
      logic [63:0] m;
      m = (re > 0) ? 64'h8000000000000001 :
          (re <= -64) ? 64'h0 : (64'h8000000000000001 >> (-re));
      op(f, 96'h0, 96'h0, 1'b0, 1'b0, 1'b0, 17'(re), 64'h8000000000000001);
      chk(underflow, uf);
      chk(overflow, ofl);
      chk(den_exp, (re > 0) ? 17'(re) : 17'h0);
      chk(den_mant, m);
   endtask : rng

   task automatic t_range();
      rng(SG, 1, 1'b0, 1'b0);
      rng(SG, 0, 1'b1, 1'b0);
      rng(SG, -4, 1'b1, 1'b0);
      rng(SG, -63, 1'b1, 1'b0);
      rng(SG, -64, 1'b1, 1'b0);
      rng(SG, 254, 1'b0, 1'b0);
      rng(SG, 255, 1'b0, 1'b1);
      rng(DB, 2046, 1'b0, 1'b0);
      rng(DB, 2047, 1'b0, 1'b1);
      rng(EX, 32766, 1'b0, 1'b0);
      rng(EX, 32767, 1'b0, 1'b1);
   endtask : t_range

   initial begin
      repeat (12) @(posedge mclk);
      @(negedge mclk);
      rst_n = 1'b1;
      @(posedge mclk);
      #1;
      chk(out_valid, 1'b0);
      chk(a_class, FPC_RST_CLS);
      chk(nan_valid, 1'b0);
      t_single();
      t_double();
      t_ext();
      t_gen();
      t_dyadic();
      t_range();
      close_out();
   end
endmodule : fpc_top_tb
